// [conv_frame_pkg.sv]
// Shared constants and carrier types for the converter frame controller
package conv_frame_pkg;

  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int unsigned SYNC_STAGES    = 2;
  localparam logic [4:0]  FRAME_EDGES    = 5'd16;
  localparam logic [4:0]  LEAD_ZEROS     = 5'd3;
  localparam int unsigned RESULT_BITS    = 12;
  localparam logic [4:0]  SHDN_FIRST     = 5'd2;
  localparam logic [4:0]  NORMAL_EDGE    = 5'd10;
  localparam logic [4:0]  TRACK_RISE     = 5'd13;
  localparam logic [4:0]  EDGE_CNT_RST   = 5'd0;
  localparam logic [1:0]  WAKE_FRAMES    = 2'd2;

  // ----------------------------------------
  // Power modes and carrier types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SHUTDOWN,
    MODE_WAKING
  } power_mode_t;

  typedef struct packed {
    logic sclk;
    logic frame_sel_b;
  } link_in_t;

  typedef struct packed {
    logic data;
    logic oe;
  } result_pin_t;

endpackage : conv_frame_pkg

// [pin_sync.sv]
// Two-stage synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import conv_frame_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst_b,
  input  wire link_in_t raw,
  output var  link_in_t synced
);

  typedef struct packed {
    link_in_t meta;
    link_in_t stable;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // ----------------------------------------
  // Idle pins read as select high, clock high
  // ----------------------------------------
  always_comb
  begin
    next_state.meta   = raw;
    next_state.stable = state.meta;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= '{meta: '{sclk: 1'b1, frame_sel_b: 1'b1}, stable: '{sclk: 1'b1, frame_sel_b: 1'b1}};
    else
      state <= next_state;
  end

  assign synced = state.stable;

endmodule // pin_sync
`default_nettype wire

// [conv_frame_ctrl.sv]
// Frame, shift-out and power-mode control of the serial converter
//
// Function
// - Output released after sixteen edges; host waits quiet time before reselecting.
// - Select released between edges two and ten: shutdown, abort, tristate output.
// - Select released before the second falling edge leaves mode unchanged.
// - Select in shutdown starts power-up; first result dummy, second valid.
// - Wake frame released before tenth falling edge returns device to shutdown.
// - Fully powered up after sixteen clock cycles of the wake frame.
// - Select falling samples input, enters hold, drives the result output.
// - Three zeros then twelve result bits MSB first, on falling edges.
// - Return from hold to track on the thirteenth rising clock edge.
// - Release between edges ten and sixteen keeps normal, aborts, tristates output.
`timescale 1ns/1ps
`default_nettype none
module conv_frame_ctrl
  import conv_frame_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   sclk,
  input  wire logic                   frame_sel_b,
  input  wire logic [RESULT_BITS-1:0] sample_code,
  output var  logic                   serial_result_out,
  output var  logic                   serial_result_oe,
  output var  logic                   hold_active,
  output var  logic                   sample_strobe,
  output var  logic                   powered_down,
  output var  logic                   result_valid
);

  typedef struct packed {
    logic                   sclk_q;
    logic                   sel_b_q;
    logic [4:0]             edge_cnt;
    logic [4:0]             rise_cnt;
    logic                   in_frame;
    logic [RESULT_BITS-1:0] shift;
    power_mode_t            mode;
    logic [1:0]             wake_cnt;
    result_pin_t            pin;
    logic                   hold;
    logic                   strobe;
  } ctrl_state_t;

  link_in_t    raw_pins;
  link_in_t    link;
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        sel_fall;
  logic        sel_rise;
  logic [4:0]  fall_num;
  logic [4:0]  rise_num;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .raw      (raw_pins),
    .synced   (link)
  );

  assign raw_pins = '{sclk: sclk, frame_sel_b: frame_sel_b};

  // ----------------------------------------
  // Edge detection and counting
  // ----------------------------------------
  function automatic logic is_fall(input logic prev, input logic now);
    is_fall = prev & ~now;
  endfunction

  // Count after one more edge; callers stop it at sixteen
  function automatic logic [4:0] bump(input logic [4:0] count);
    bump = count + 5'd1;
  endfunction

  // Mode left behind when select is released after a number of falls
  function automatic power_mode_t release_mode(input power_mode_t mode,
                                               input logic [4:0]  falls);
    release_mode = mode;
    if (mode == MODE_WAKING)
    begin
      // Noise on select must not wake the part
      if (falls < NORMAL_EDGE)
        release_mode = MODE_SHUTDOWN;
      else
        release_mode = MODE_NORMAL;
    end
    // Before the second fall mode is kept, as glitch rejection
    else if (mode == MODE_NORMAL && falls >= SHDN_FIRST && falls < NORMAL_EDGE)
      release_mode = MODE_SHUTDOWN;
  endfunction

  assign sclk_fall = is_fall(state.sclk_q, link.sclk);
  assign sclk_rise = is_fall(link.sclk, state.sclk_q);
  assign sel_fall  = is_fall(state.sel_b_q, link.frame_sel_b);
  assign sel_rise  = is_fall(link.frame_sel_b, state.sel_b_q);
  assign fall_num  = bump(state.edge_cnt);
  assign rise_num  = bump(state.rise_cnt);

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  always_comb
  begin
    next_state         = state;
    next_state.sclk_q  = link.sclk;
    next_state.sel_b_q = link.frame_sel_b;
    next_state.strobe  = 1'b0;

    if (sel_fall)
    begin
      // Fresh select fall only; idling low never re-triggers
      next_state.in_frame = 1'b1;
      next_state.edge_cnt = EDGE_CNT_RST;
      next_state.rise_cnt = EDGE_CNT_RST;
      next_state.shift    = sample_code;
      next_state.hold     = 1'b1;
      next_state.strobe   = 1'b1;
      next_state.pin.oe   = 1'b1;
      next_state.pin.data = 1'b0;
      if (state.mode == MODE_SHUTDOWN)
      begin
        next_state.mode     = MODE_WAKING;
        next_state.wake_cnt = 2'd0;
      end
    end
    else if (sel_rise)
    begin
      next_state.in_frame = 1'b0;
      next_state.edge_cnt = EDGE_CNT_RST;
      next_state.pin.oe   = 1'b0;
      // Released pin reads low, no stale result bit lingers
      next_state.pin.data = 1'b0;
      next_state.hold     = 1'b0;
      next_state.mode     = release_mode(state.mode, state.edge_cnt);
    end
    else if (state.in_frame && !link.frame_sel_b)
    begin
      if (sclk_rise && state.rise_cnt < FRAME_EDGES)
      begin
        next_state.rise_cnt = rise_num;
        if (rise_num == TRACK_RISE)
          next_state.hold = 1'b0;
      end
      if (sclk_fall && state.edge_cnt < FRAME_EDGES)
      begin
        next_state.edge_cnt = fall_num;
        if (fall_num == FRAME_EDGES)
        begin
          next_state.pin.oe   = 1'b0;
          next_state.pin.data = 1'b0;
          if (state.mode == MODE_WAKING)
            next_state.mode = MODE_NORMAL;
        end
        else if (fall_num < LEAD_ZEROS)
          next_state.pin.data = 1'b0;
        else
        begin
          // Lead zeros done, result MSB first
          next_state.pin.data = state.shift[RESULT_BITS-1];
          next_state.shift    = {state.shift[RESULT_BITS-2:0], 1'b0};
        end
        if (fall_num == FRAME_EDGES && state.mode != MODE_SHUTDOWN
            && state.wake_cnt < WAKE_FRAMES)
          next_state.wake_cnt = state.wake_cnt + 2'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state          <= '0;
      state.sclk_q   <= 1'b1;
      state.sel_b_q  <= 1'b1;
      // Power-up mode is unknown to the host; shutdown is the safe pick
      state.mode     <= MODE_SHUTDOWN;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
      hold_active       <= 1'b0;
      sample_strobe     <= 1'b0;
      powered_down      <= 1'b1;
      result_valid      <= 1'b0;
    end
    else
    begin
      serial_result_out <= next_state.pin.data;
      serial_result_oe  <= next_state.pin.oe;
      hold_active       <= next_state.hold;
      sample_strobe     <= next_state.strobe;
      powered_down      <= (next_state.mode == MODE_SHUTDOWN);
      // Dummy frame after wake is flagged unusable
      result_valid      <= (next_state.mode == MODE_NORMAL)
                           && (next_state.wake_cnt >= WAKE_FRAMES);
    end
  end

endmodule // conv_frame_ctrl
`default_nettype wire

// [conv_frame_ctrl_chk.sv]
// Port assertions for the converter frame controller
`timescale 1ns/1ps
`default_nettype none
module conv_frame_ctrl_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic frame_sel_b,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic hold_active,
  input wire logic sample_strobe,
  input wire logic powered_down,
  input wire logic result_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Six cycles covers sync plus output latency
  property p_rel_oe; frame_sel_b [*6] |-> !serial_result_oe; endproperty
  a_rel_oe: assert property (p_rel_oe) else $error("output driven while deselected");
  property p_rel_hold; frame_sel_b [*6] |-> !hold_active; endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("hold while deselected");
  property p_rel_mode; frame_sel_b [*6] |=> $stable(powered_down); endproperty
  a_rel_mode: assert property (p_rel_mode) else $error("mode moved while idle");
  property p_out_low; !serial_result_oe |-> !serial_result_out; endproperty
  a_out_low: assert property (p_out_low) else $error("bit high while released");
  property p_oe_start; $rose(serial_result_oe) |-> sample_strobe && hold_active; endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive without sample");
  property p_strobe; sample_strobe |=> !sample_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_strobe_sel; sample_strobe |-> !frame_sel_b; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
  property p_valid; powered_down |-> !result_valid; endproperty
  a_valid: assert property (p_valid) else $error("valid in shutdown");
endmodule // conv_frame_ctrl_chk
bind conv_frame_ctrl conv_frame_ctrl_chk conv_frame_ctrl_chk_i (
  .core_clk(core_clk), .rst_b(rst_b), .frame_sel_b(frame_sel_b),
  .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
  .hold_active(hold_active), .sample_strobe(sample_strobe),
  .powered_down(powered_down), .result_valid(result_valid));
`default_nettype wire

// [conv_host_model.sv]
// Host side model: drives select and serial clock, captures result bits
`timescale 1ns/1ps
`default_nettype none
module conv_host_model (
  input  wire logic core_clk,
  input  wire logic data_in,
  input  wire logic data_oe,
  output var  logic sclk,
  output var  logic frame_sel_b
);
  initial sclk = 1'b1;
  initial frame_sel_b = 1'b1;
  // Low phase 5 cycles so capture sees the settled bit
  task automatic frame(input int falls, output logic [15:0] w);
    w = 16'h0000;
    frame_sel_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < falls; k++)
    begin
      sclk <= 1'b0;
      repeat (5) @(posedge core_clk);
      w = {w[14:0], data_oe ? data_in : ~w[0]};
      sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
    // Release after last rise: count decides mode
    frame_sel_b <= 1'b1;
    // Four idle clock periods: quiet time and rate limit
    repeat (32) @(posedge core_clk);
  endtask
endmodule // conv_host_model
`default_nettype wire

// [conv_frame_ctrl_bench.sv]
// Testbench for the converter frame controller
`timescale 1ns/1ps
`default_nettype none
module conv_frame_ctrl_bench;
  import conv_frame_pkg::*;
  logic                   core_clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [RESULT_BITS-1:0] sample_code = 12'ha5c;
  logic                   sclk, frame_sel_b, out, oe, hold, strobe, pd, valid;
  logic [15:0]            w;
  int                     err_total = 0;
  int                     compares = 0;
  conv_frame_ctrl conv_frame_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
    .frame_sel_b(frame_sel_b), .sample_code(sample_code), .serial_result_out(out),
    .serial_result_oe(oe), .hold_active(hold), .sample_strobe(strobe),
    .powered_down(pd), .result_valid(valid));
  conv_host_model conv_host_model_i (.core_clk(core_clk), .data_in(out), .data_oe(oe),
    .sclk(sclk), .frame_sel_b(frame_sel_b));
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic t_wake;
    chk(pd, 1'b1);
    conv_host_model_i.frame(16, w);
    chk({pd, valid}, 2'b00);
    conv_host_model_i.frame(16, w);
    chk(w[15:1], {2'b00, sample_code, 1'b0});
    chk({pd, valid, oe}, 3'b010);
    $display("wake done");
  endtask
  task automatic t_glitch_trunc;
    sample_code <= 12'h3c7;
    conv_host_model_i.frame(1, w);
    chk({pd, oe}, 2'b00);
    conv_host_model_i.frame(12, w);
    chk(w[11:0], {2'b00, sample_code[11:2]});
    chk({pd, oe}, 2'b00);
    $display("glitch and truncate done");
  endtask
  task automatic t_shut;
    sample_code <= 12'hfff;
    conv_host_model_i.frame(5, w);
    chk({pd, oe, valid}, 3'b100);
    conv_host_model_i.frame(5, w);
    chk(pd, 1'b1);
    conv_host_model_i.frame(12, w);
    chk({pd, valid}, 2'b00);
    conv_host_model_i.frame(3, w);
    chk({pd, oe}, 2'b10);
    conv_host_model_i.frame(16, w);
    chk({pd, valid}, 2'b00);
    $display("shutdown done");
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_wake();
    t_glitch_trunc();
    t_shut();
    complete_run();
  end
  // Roughly 1040 cycles expected; allow ample margin
  initial
  begin
    #200us;
    err_total++;
    complete_run();
  end
endmodule // conv_frame_ctrl_bench
`default_nettype wire
